// [rtl/cmd_parser_pkg.sv]
package cmd_parser_pkg;
   // Control codes of the native command set
   localparam logic [7:0] B_STX = 8'h02, B_ENQ = 8'h05, B_BEL = 8'h07, B_BS  = 8'h08;
   localparam logic [7:0] B_HT  = 8'h09, B_LF  = 8'h0A, B_VT  = 8'h0B, B_FF  = 8'h0C;
   localparam logic [7:0] B_CR  = 8'h0D, B_SO  = 8'h0E, B_SI  = 8'h0F, B_DLE = 8'h10;
   localparam logic [7:0] B_DC1 = 8'h11, B_DC2 = 8'h12, B_DC3 = 8'h13, B_DC4 = 8'h14;
   localparam logic [7:0] B_ETB = 8'h17, B_EM  = 8'h19, B_SUB = 8'h1A, B_ESC = 8'h1B;
   localparam logic [7:0] B_FS  = 8'h1C, B_GS  = 8'h1D, B_RS  = 8'h1E, B_US  = 8'h1F;
   localparam logic [7:0] B_A   = 8'h41, B_B   = 8'h42, B_E   = 8'h45, B_F   = 8'h46;
   localparam logic [7:0] B_I   = 8'h49, B_J   = 8'h4A, B_RBR = 8'h5D, B_TIL = 8'h7E;
   localparam logic [7:0] B_QM  = 8'h3F, B_AT  = 8'h40, B_NINE = 8'h39, B_ZERO = 8'h30;
   localparam logic [3:0] ESC_STEP_HI = 4'h3;  // ESC n: upper nibble of n
   // Keypad codes seen on the key port
   localparam logic [7:0] KEY_ENTER = 8'h45, KEY_FUNCTION_KEY = 8'h46, KEY_CLEAR = 8'h43;
   // Parameter byte tag 01xxxxxx
   localparam logic [1:0] TAG_01 = 2'b01;
   // Counts
   localparam int        DISP_LEN  = 16;
   localparam int        KEY_DEPTH = 16;
   localparam logic [9:0] GFX_MAX60 = 10'd480, GFX_MAX120 = 10'd960;
   localparam int        BUF_ROOM  = 1000;
   localparam logic [6:0] CUT_9W = 7'd33, CUT_24W = 7'd50;
   // APB map
   localparam logic [7:0] A_CTRL = 8'h00, A_STATUS = 8'h04, A_CFG = 8'h08;
   localparam int CTRL_BLOCK = 0, CTRL_WIDE24 = 1;
   // Config byte 1 fields (01PVHFCS) and byte 2 (01LEIBDQ)
   localparam int F_P = 5, F_V = 4, F_H = 3, F_F = 2, F_C = 1, F_S = 0;
   localparam int F_L = 5, F_E = 4, F_I = 3, F_B = 2, F_D = 1, F_Q = 0;

   typedef enum logic [1:0] {CPI_10, CPI_12, CPI_17} pitch_t;
   typedef enum logic [1:0] {Q_NORMAL, Q_CORR, Q_DRAFT} qual_t;
   typedef enum logic [4:0] {
      C_CHAR, C_LINE, C_LF, C_REV, C_VT, C_STEP120, C_STEP216, C_EJECT,
      C_BLANKS, C_ENV_TOP, C_ENV_LEFT, C_FLUSH, C_ALT, C_RAW_ALT,
      C_DISP_UP, C_DISP_LO, C_GFX60, C_GFX120, C_DOTS
   } cmd_code_t;
   typedef enum logic [3:0] {
      P_IDLE, P_ESC, P_TIL, P_RS, P_STX_X, P_STX_Y, P_HT1, P_HT2,
      P_VT, P_ESCJ, P_DISP, P_WAIT, P_ALT
   } pstate_t;
   typedef enum logic [1:0] {T_IDLE, T_STAT, T_KEYS, T_TWO} tstate_t;

   typedef struct packed {
      logic wide, high, bold, under;
   } attr_t;
   typedef struct packed {
      logic  permanent, lpi5, script, lock, enter_conf, down_ins, bottom_ins, quiet;
      pitch_t pitch;
      qual_t  quality;
   } cfg_t;
   typedef struct packed {
      cmd_code_t code;
      logic [7:0] arg;
      logic [3:0] idx;
      attr_t      attr;
   } cmd_t;
   typedef struct packed {
      pstate_t    ps;
      logic [4:0] cnt;      // Display byte counter
      logic       disp_lo;  // Display target line
      logic       wait_sub; // Delayed action: status or display
      logic [7:0] cfg1;
      logic [1:0] ctrl;
      attr_t      attr;
      cfg_t       cfg;
      logic       gfx, gfx120;
      logic [9:0] gcnt;
      logic       cv;       // Command slot full
      cmd_t       cmd;
      logic       hv;       // Held movement command
      cmd_t       held;
      logic       ign, fault;
      tstate_t    ts;
      logic       tv;
      logic [7:0] td, b1;
      logic [4:0] ti;
      logic [KEY_DEPTH-1:0][7:0] kbuf;
      logic [4:0] kcnt, scnt;
      logic [7:0] cfg2;
   } st_t;
endpackage : cmd_parser_pkg

// [rtl/cmd_parser.sv]
// Chosen here: register access over APB and the address map.
`timescale 1ns/10ps
module cmd_parser import cmd_parser_pkg::*; #(
   parameter int BUF_W = 12          // Width of free-space count
) (
   input  wire logic             clock_i,
   input  wire logic             rst_b_i,
   // APB slave
   input  wire logic             psel_i,
   input  wire logic             penable_i,
   input  wire logic             pwrite_i,
   input  wire logic [7:0]       paddr_i,
   input  wire logic [31:0]      pwdata_i,
   output logic      [31:0]      prdata_o,
   output logic                  pready_o,
   output logic                  pslverr_o,
   // Host byte stream
   input  wire logic             rx_valid_i,
   input  wire logic [7:0]       rx_data_i,
   input  wire logic             rx_err_i,
   output logic                  rx_ready_o,
   // Reply bytes to host
   output logic                  tx_valid_o,
   output logic      [7:0]       tx_data_o,
   input  wire logic             tx_ready_i,
   // Commands to print engine, display and buffer
   output logic                  cmd_valid_o,
   output cmd_t                  cmd_o,
   input  wire logic             cmd_ready_i,
   output cfg_t                  cfg_o,
   output logic      [6:0]       speed_cut_o,
   output logic                  alt_mode_o,
   // Mechanism state
   input  wire logic             document_loaded_flag_i,
   input  wire logic             paper_stuck_flag_i,
   input  wire logic             activity_flag_i,
   input  wire logic             buf_empty_i,
   input  wire logic [BUF_W-1:0] buf_free_i,
   input  wire logic [7:0]       line_cnt_i,
   input  wire logic [7:0]       step_cnt_i,
   input  wire logic [7:0]       len_lines_i,
   input  wire logic [7:0]       len_steps_i,
   // Keypad
   input  wire logic             key_valid_i,
   input  wire logic [7:0]       key_code_i
);
   st_t        s_r, s_nxt;   // Whole state
   logic [7:0] status;       // Status byte
   logic       take;         // Byte accepted this cycle
   logic       stall;        // Second held movement would be lost
   logic       idle;         // Engine and queue empty

   // Status byte assembly
   always_comb begin
      status = {TAG_01, document_loaded_flag_i, s_r.fault, paper_stuck_flag_i,
                (s_r.kcnt != '0), activity_flag_i,
                buf_empty_i || (32'(buf_free_i) >= BUF_ROOM)};
   end

   // Idle means no engine activity, no command in the slot and no held movement
   assign idle       = !activity_flag_i && !s_r.cv && !s_r.hv;
   assign rx_ready_o = !s_r.cv && !s_r.tv && s_r.ps != P_WAIT && !stall;
   assign take       = rx_valid_i && rx_ready_o;
   assign tx_valid_o = s_r.tv;
   assign tx_data_o  = s_r.td;
   assign cmd_valid_o = s_r.cv;
   assign cmd_o      = s_r.cmd;
   assign cfg_o      = s_r.cfg;
   assign alt_mode_o = s_r.ps == P_ALT;
   assign speed_cut_o = !s_r.attr.bold ? 7'd0 : (s_r.ctrl[CTRL_WIDE24] ? CUT_24W : CUT_9W);
   assign pready_o   = 1'b1;

   // APB read mux and error on unmapped address
   always_comb begin
      prdata_o  = '0;
      pslverr_o = 1'b0;
      unique case (paddr_i)
         A_CTRL:   prdata_o = {30'd0, s_r.ctrl};
         A_STATUS: prdata_o = {24'd0, status};
         A_CFG:    prdata_o = {16'd0, s_r.cfg2, s_r.cfg1};
         default:  pslverr_o = psel_i && penable_i;
      endcase
   end

   // Next state: parser, reply sender, key buffer, registers
   always_comb begin
      logic       ev;        // Command produced by this byte
      cmd_t       ec;
      logic       feed;      // Byte ends line attributes
      logic [7:0] b;
      logic [4:0] base;
      ev    = 1'b0;
      ec    = '{code: C_CHAR, arg: 8'h00, idx: 4'h0, attr: s_r.attr};
      feed  = 1'b0;
      b     = rx_data_i;
      base  = s_r.kcnt;
      stall = 1'b0;
      s_nxt = s_r;
      // Engine took the command
      if (s_r.cv && cmd_ready_i) begin
         s_nxt.cv = 1'b0;
      end
      // Reply sender
      if (s_r.tv && tx_ready_i) begin
         s_nxt.tv = 1'b0;
         unique case (s_r.ts)
            T_KEYS: begin
               if (s_r.ti < s_r.kcnt) begin
                  s_nxt.tv = 1'b1;
                  s_nxt.td = s_r.kbuf[s_r.ti[3:0]];
                  s_nxt.ti = s_r.ti + 5'd1;
               end else if (s_r.td != B_QM) begin
                  s_nxt.tv = 1'b1;
                  s_nxt.td = B_QM;
               end else begin
                  s_nxt.kcnt = '0;
                  s_nxt.scnt = '0;
                  s_nxt.ts   = T_IDLE;
               end
            end
            T_TWO: begin
               s_nxt.tv = 1'b1;
               s_nxt.td = s_r.b1;
               s_nxt.ts = T_STAT;
            end
            default: s_nxt.ts = T_IDLE;
         endcase
      end
      // Delayed status or display load waits for idle
      if (s_r.ps == P_WAIT && idle && !s_r.tv) begin
         s_nxt.ps = s_r.wait_sub ? P_IDLE : P_DISP;
         if (s_r.wait_sub) begin
            s_nxt.tv = 1'b1;
            s_nxt.td = status;
            s_nxt.ts = T_STAT;
         end
      end
      // Byte decoder, one byte at a time in arrival order
      if (rx_valid_i && !s_r.cv && !s_r.tv && s_r.ps != P_WAIT) begin
         if (rx_err_i && s_r.ps != P_ALT) begin
            s_nxt.fault = 1'b1;
            if (s_r.ctrl[CTRL_BLOCK]) s_nxt.ign = 1'b1;
            else b = B_AT;
         end
         if ((s_r.ign || (rx_err_i && s_r.ctrl[CTRL_BLOCK])) && b != B_ENQ) begin
            // Dropped until the next enquiry
         end else begin
            unique case (s_r.ps)
               P_IDLE: begin
                  unique case (b)
                     B_CR:  begin ev = 1'b1; ec.code = C_LINE; feed = 1'b1; end
                     B_LF:  begin ev = 1'b1; ec.code = C_LF; feed = 1'b1; end
                     B_BS:  begin ev = 1'b1; ec.code = C_REV; feed = 1'b1; end
                     B_FF:  begin ev = 1'b1; ec.code = C_EJECT; feed = 1'b1; end
                     B_VT:  s_nxt.ps = P_VT;
                     B_SO:  s_nxt.attr.wide = 1'b1;
                     B_SI:  s_nxt.attr.wide = 1'b0;
                     B_US:  s_nxt.attr.under = !s_r.attr.under;
                     B_RS:  s_nxt.ps = P_RS;
                     B_STX: s_nxt.ps = P_STX_X;
                     B_HT:  s_nxt.ps = P_HT1;
                     B_ESC: s_nxt.ps = P_ESC;
                     B_DC4: begin ev = 1'b1; ec.code = C_FLUSH; end
                     B_BEL, B_FS: begin
                        s_nxt.ps = P_DISP;
                        s_nxt.disp_lo = b == B_FS;
                        s_nxt.cnt = '0;
                     end
                     B_DC3, B_ETB, B_GS: begin
                        s_nxt.ps = P_WAIT;
                        s_nxt.wait_sub = 1'b0;
                        s_nxt.disp_lo = b == B_GS;
                        s_nxt.cnt = '0;
                     end
                     B_ENQ: begin
                        s_nxt.tv = 1'b1;
                        s_nxt.td = status;
                        s_nxt.ts = T_STAT;
                        s_nxt.ign = 1'b0;
                        s_nxt.fault = rx_err_i;
                        if (s_r.hv) begin
                           s_nxt.cv  = 1'b1;
                           s_nxt.cmd = s_r.held;
                           s_nxt.hv  = 1'b0;
                        end
                     end
                     B_SUB: begin
                        s_nxt.ps = P_WAIT;
                        s_nxt.wait_sub = 1'b1;
                     end
                     B_DC1, B_DLE: begin
                        s_nxt.tv = 1'b1;
                        s_nxt.ts = T_KEYS;
                        s_nxt.td = s_r.kcnt == '0 ? B_QM : s_r.kbuf[0];
                        s_nxt.ti = s_r.kcnt == '0 ? '0 : 5'd1;
                     end
                     B_DC2, B_EM: begin
                        s_nxt.tv = 1'b1;
                        s_nxt.ts = T_TWO;
                        s_nxt.td = b == B_DC2 ? line_cnt_i : len_lines_i;
                        s_nxt.b1 = b == B_DC2 ? step_cnt_i : len_steps_i;
                     end
                     default: begin
                        ev = 1'b1;
                        ec.arg = b;
                        if (s_r.gfx) begin
                           ec.code = C_DOTS;
                           ec.arg  = {2'b00, b[5:0]};
                           ev = s_r.gcnt < (s_r.gfx120 ? GFX_MAX120 : GFX_MAX60);
                           s_nxt.gcnt = s_r.gcnt + 10'd1;
                        end
                     end
                  endcase
               end
               P_ESC: begin
                  s_nxt.ps = P_IDLE;
                  unique case (b)
                     B_SO: s_nxt.attr.high = 1'b1;
                     B_SI: s_nxt.attr.high = 1'b0;
                     B_E:  s_nxt.attr.bold = 1'b1;
                     B_F:  s_nxt.attr.bold = 1'b0;
                     B_J:  s_nxt.ps = P_ESCJ;
                     B_RBR: begin ev = 1'b1; ec.code = C_REV; feed = 1'b1; end
                     B_TIL: s_nxt.ps = P_TIL;
                     B_A, B_B: begin
                        ev = 1'b1;
                        ec.code = b == B_A ? C_GFX60 : C_GFX120;
                        s_nxt.gfx = 1'b1;
                        s_nxt.gfx120 = b == B_B;
                        s_nxt.gcnt = '0;
                     end
                     default: begin
                        if (b[7:4] == ESC_STEP_HI) begin
                           ev = 1'b1;
                           ec.code = C_STEP120;
                           ec.arg = {4'h0, b[3:0]};
                           feed = 1'b1;
                        end
                     end
                  endcase
               end
               P_TIL: begin
                  s_nxt.ps = b == B_I ? P_ALT : P_IDLE;
                  ev = b == B_I;
                  ec.code = C_ALT;
               end
               P_ESCJ, P_VT: begin
                  s_nxt.ps = P_IDLE;
                  ev = 1'b1;
                  ec.code = s_r.ps == P_VT ? C_VT : C_STEP216;
                  ec.arg = b;
                  feed = 1'b1;
               end
               P_RS: begin
                  s_nxt.ps = P_IDLE;
                  ev = 1'b1;
                  ec.code = C_BLANKS;
                  ec.arg = {2'b00, b[5:0]};
               end
               P_STX_X, P_STX_Y: begin
                  s_nxt.ps = s_r.ps == P_STX_X ? P_STX_Y : P_IDLE;
                  ev = 1'b1;
                  ec.code = s_r.ps == P_STX_X ? C_ENV_TOP : C_ENV_LEFT;
                  ec.arg = {2'b00, b[5:0]};
               end
               P_HT1: begin
                  s_nxt.ps = P_HT2;
                  s_nxt.cfg1 = b;
               end
               P_HT2: begin
                  s_nxt.ps = P_IDLE;
                  s_nxt.cfg2 = b;
                  s_nxt.cfg.permanent = s_r.cfg1[F_P];
                  s_nxt.cfg.lpi5 = s_r.cfg1[F_V];
                  s_nxt.cfg.script = s_r.cfg1[F_F];
                  s_nxt.cfg.pitch = s_r.cfg1[F_S] ? CPI_17 :
                                    (s_r.cfg1[F_H] ? CPI_12 : CPI_10);
                  s_nxt.cfg.quality = (s_r.cfg1[F_C] && !s_r.cfg1[F_S]) ? Q_CORR :
                                      (!s_r.cfg1[F_C] && b[F_D]) ? Q_DRAFT : Q_NORMAL;
                  s_nxt.cfg.lock = b[F_L];
                  s_nxt.cfg.enter_conf = b[F_E];
                  s_nxt.cfg.down_ins = b[F_I];
                  s_nxt.cfg.bottom_ins = b[F_B];
                  s_nxt.cfg.quiet = b[F_Q];
               end
               P_DISP: begin
                  ev = 1'b1;
                  ec.code = s_r.disp_lo ? C_DISP_LO : C_DISP_UP;
                  ec.arg = b;
                  ec.idx = s_r.cnt[3:0];
                  s_nxt.cnt = s_r.cnt + 5'd1;
                  if (s_r.cnt == 5'(DISP_LEN - 1)) s_nxt.ps = P_IDLE;
               end
               P_ALT: begin
                  ev = 1'b1;
                  ec.code = C_RAW_ALT;
                  ec.arg = b;
               end
               default: s_nxt.ps = P_IDLE;
            endcase
         end
         // Feeds end line attributes and graphics lines
         if (feed) begin
            s_nxt.attr = '0;
            s_nxt.gfx  = 1'b0;
         end
         // Movement in block mode waits for an enquiry
         if (ev && feed && s_r.ctrl[CTRL_BLOCK]) begin
            if (s_r.hv) begin
               stall = 1'b1;
               s_nxt = s_r;
               s_nxt.cv = s_r.cv && !cmd_ready_i;
            end else begin
               s_nxt.hv = 1'b1;
               s_nxt.held = ec;
            end
         end else if (ev) begin
            s_nxt.cv  = 1'b1;
            s_nxt.cmd = ec;
         end
      end
      // APB write after the decoder, so a stalled byte cannot undo it
      if (psel_i && penable_i && pwrite_i && paddr_i == A_CTRL) begin
         s_nxt.ctrl = pwdata_i[1:0];
      end
      // Keypad: digits staged, committed by any non-digit key that still fits in the buffer, except CLEAR,
      // or FUNCTION_KEY when the first staged digit is 9, which drop them
      if (key_valid_i && s_r.ts != T_KEYS) begin
         if (key_code_i == KEY_CLEAR) begin
            s_nxt.scnt = '0;
         end else if (key_code_i == KEY_FUNCTION_KEY && s_r.scnt != '0 && s_r.kbuf[base[3:0]] == B_NINE) begin
            s_nxt.scnt = '0;
         end else if (32'(s_r.kcnt) + 32'(s_r.scnt) < KEY_DEPTH) begin
            s_nxt.kbuf[4'(s_r.kcnt + s_r.scnt)] = key_code_i;
            if (key_code_i >= B_ZERO && key_code_i <= B_NINE) begin
               s_nxt.scnt = s_r.scnt + 5'd1;
            end else begin
               s_nxt.kcnt = s_r.kcnt + s_r.scnt + 5'd1;
               s_nxt.scnt = '0;
            end
         end
      end
   end

   // State register
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Checks
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_take(logic [7:0] c);
      take && !rx_err_i && !s_r.ign && s_r.ps == P_IDLE && rx_data_i == c;
   endsequence
   sequence s_esc_then(logic [7:0] c);
      s_take(B_ESC) ##[1:8] (take && rx_data_i == c && s_r.ps == P_ESC);
   endsequence
   AST_CR_PRINTS: assert property (s_take(B_CR) && !s_r.ctrl[CTRL_BLOCK] |=>
      s_r.cv && s_r.cmd.code == C_LINE && s_r.attr == '0) else $error("CR did not print line");
   AST_SO_WIDE: assert property (s_take(B_SO) |=> s_r.attr.wide)
      else $error("SO did not set double width");
   AST_ESC_SO_HIGH: assert property (s_esc_then(B_SO) |=> s_r.attr.high)
      else $error("ESC SO did not set double height");
   AST_BOLD_CUT: assert property (s_r.attr.bold |->
      speed_cut_o == (s_r.ctrl[CTRL_WIDE24] ? CUT_24W : CUT_9W)) else $error("Bold speed cut wrong");
   AST_RS_COUNT: assert property (s_take(B_RS) ##[1:8] (take && !rx_err_i && s_r.ps == P_RS) |=>
      s_r.cmd.code == C_BLANKS && s_r.cmd.arg[5:0] == $past(rx_data_i[5:0])) else $error("RS count wrong");
   AST_US_TOGGLE: assert property (s_take(B_US) |=> s_r.attr.under != $past(s_r.attr.under))
      else $error("US did not toggle underscore");
   AST_ENQ_STATUS: assert property (s_take(B_ENQ) |=> tx_valid_o && tx_data_o[7:6] == TAG_01)
      else $error("ENQ reply missing");
   AST_AVAIL: assert property (buf_empty_i |-> status[0]) else $error("Buffer available clear");
   AST_KEYS_EMPTY: assert property (s_take(B_DC1) && s_r.kcnt == '0 |=>
      tx_valid_o && tx_data_o == B_QM) else $error("Empty key reply not ?");
   AST_HOLD_FEED: assert property (s_take(B_LF) && s_r.ctrl[CTRL_BLOCK] && !s_r.hv |=>
      s_r.hv && s_r.held.code == C_LF ##1 (s_r.hv || s_r.cv))
      else $error("Feed not held in block mode");
endmodule : cmd_parser

// [sim/host_model.sv]
`timescale 1ns/10ps
// Host side: sends bytes, always takes replies
module host_model import cmd_parser_pkg::*; (
   input  wire logic       clock_i,
   input  wire logic       rx_ready_i,
   output logic            rx_valid_o,
   output logic [7:0]      rx_data_o,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   output logic            tx_ready_o,
   output logic [7:0]      last_tx_o
);
   initial begin
      rx_valid_o = 1'h0;
      rx_data_o = 8'hA5;
      tx_ready_o = 1'h1;
   end
   // Latch each accepted reply byte
   always @(posedge clock_i) if (tx_valid_i) last_tx_o <= tx_data_i;
   // Held until taken; data inverted after so stale bytes never match
   task automatic send(input logic [7:0] b);
      @(posedge clock_i);
      rx_valid_o <= 1'h1;
      rx_data_o <= b;
      // Byte stands until the rising edge that sees ready high
      do @(posedge clock_i); while (rx_ready_i !== 1'h1);
      rx_valid_o <= 1'h0;
      rx_data_o <= ~b;
   endtask : send
endmodule : host_model

// [sim/tb.sv]
`timescale 1ns/10ps
module tb import cmd_parser_pkg::*; ;
   logic        clock_i = 1'h0, rst_b_i = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
   logic        rdy, err, er, rxv, rxr, txv, txr, cv, doc = 1'h1, emp = 1'h1, kv = 1'h0;
   logic        alt;  // Alternate set selected
   logic [7:0]  pa = 8'h00, rxd, txd, lt, ln = 8'h00, kc = 8'h00;
   logic [31:0] pwd = 32'h0, prd, rd;
   logic [11:0] fr = 12'h000;
   cmd_t        cmd, lc;  // Last command taken
   cfg_t        cfg;      // Decoded configuration
   logic [6:0]  cut;
   int          fail_count = 0, comparisons = 0;
   int          ntx = 0, n0 = 0;  // Reply bytes seen
   always #10 clock_i = ~clock_i;
   always @(posedge clock_i) if (cv) lc <= cmd;
   // Count every reply byte the host takes
   always @(posedge clock_i) if (txv && txr) ntx <= ntx + 1;
   host_model host (.clock_i(clock_i), .rx_ready_i(rxr), .rx_valid_o(rxv), .rx_data_o(rxd),
      .tx_valid_i(txv), .tx_data_i(txd), .tx_ready_o(txr), .last_tx_o(lt));
   cmd_parser uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
      .rx_valid_i(rxv), .rx_data_i(rxd), .rx_err_i(1'h0), .rx_ready_o(rxr), .tx_valid_o(txv),
      .tx_data_o(txd), .tx_ready_i(txr), .cmd_valid_o(cv), .cmd_o(cmd), .cmd_ready_i(1'h1),
      .cfg_o(cfg), .speed_cut_o(cut), .alt_mode_o(alt), .document_loaded_flag_i(doc),
      .paper_stuck_flag_i(1'h0), .activity_flag_i(1'h0), .buf_empty_i(emp), .buf_free_i(fr),
      .line_cnt_i(ln), .step_cnt_i(ln), .len_lines_i(ln), .len_steps_i(ln),
      .key_valid_i(kv), .key_code_i(kc));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // APB cycle; result taken at the edge that sees pready high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      psel <= 1'h1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clock_i);
      pen <= 1'h1;
      do @(posedge clock_i); while (rdy !== 1'h1);
      rd = prd;
      er = err;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask : apb
   // One keypad stroke, a single cycle pulse
   task automatic key(input logic [7:0] k);
      @(posedge clock_i);
      kv <= 1'h1;
      kc <= k;
      @(posedge clock_i);
      kv <= 1'h0;
   endtask : key
   // One byte, then the answer settles
   task automatic go(input logic [7:0] b);
      host.send(b);
      repeat (2) @(posedge clock_i);
   endtask : go
   task automatic t_attr;
      go(B_SO);
      go(B_A);
      chk({lc.code, lc.attr.wide}, {C_CHAR, 1'h1});
      go(B_CR);
      chk(32'(lc.code), 32'(C_LINE));
      go(B_US);
      go(B_B);
      chk({lc.attr.wide, lc.attr.under}, 2'h1);
      go(B_RS);
      go(8'h7A);
      chk({lc.code, lc.arg[5:0]}, {C_BLANKS, 6'h3A});
      go(B_DC4);
      chk(32'(lc.code), 32'(C_FLUSH));
   endtask : t_attr
   task automatic t_bold;
      apb(1'h1, A_CTRL, 32'h2);
      apb(1'h0, A_CTRL, 32'h0);
      chk(rd, 32'h2);
      apb(1'h0, 8'h40, 32'h0);
      chk(32'(er), 32'h1);
      go(B_ESC);
      go(B_E);
      chk(32'(cut), 32'h32);
      go(B_ESC);
      go(B_F);
      chk(32'(cut), 32'h0);
   endtask : t_bold
   task automatic t_status;
      go(B_ENQ);
      chk(32'(lt), 32'h61);
      emp <= 1'h0;
      fr <= 12'h3E7;
      go(B_ENQ);
      chk(32'(lt), 32'h60);
      fr <= 12'h3E8;
      go(B_ENQ);
      chk(32'(lt), 32'h61);
      go(B_DC1);
      chk(32'(lt), 32'h3F);
      // A 9 entry is dropped by FUNCTION_KEY, a digit plus ENTER is committed
      key(B_NINE);
      key(KEY_FUNCTION_KEY);
      key(8'h31);
      key(KEY_ENTER);
      apb(1'h0, A_STATUS, 32'h0);
      chk(rd, 32'h65);
      n0 = ntx;
      go(B_DC1);
      repeat (4) @(posedge clock_i);
      chk(ntx - n0, 3);
      chk(32'(lt), 32'h3F);
      ln <= 8'h5A;
      n0 = ntx;
      go(B_DC2);
      repeat (4) @(posedge clock_i);
      chk(ntx - n0, 2);
      chk(32'(lt), 32'h5A);
   endtask : t_status
   // Envelope, display, graphics, configuration, block mode, alternate set
   task automatic t_cfg;
      go(B_STX);
      go(8'h45);
      go(8'h43);
      chk({lc.code, lc.arg}, {C_ENV_LEFT, 8'h03});
      go(B_FF);
      chk(32'(lc.code), 32'(C_EJECT));
      go(B_BEL);
      for (int i = 0; i < 16; i++) go(8'h41);
      chk({lc.code, lc.idx}, {C_DISP_UP, 4'hF});
      go(B_ESC);
      go(B_A);
      chk(32'(lc.code), 32'(C_GFX60));
      go(8'h7F);
      chk({lc.code, lc.arg}, {C_DOTS, 8'h3F});
      go(B_CR);
      go(B_HT);
      go(8'h6A);
      go(8'h6B);
      chk(32'(cfg), {20'h0, 8'h95, CPI_12, Q_CORR});
      apb(1'h0, A_CFG, 32'h0);
      chk(rd, 32'h6B6A);
      // Block protocol: the feed waits for the enquiry
      apb(1'h1, A_CTRL, 32'h1);
      go(B_LF);
      chk(32'(lc.code), 32'(C_LINE));
      go(B_ENQ);
      chk(32'(lc.code), 32'(C_LF));
      // Last, since the alternate set stays until reset
      go(B_ESC);
      go(B_TIL);
      go(B_I);
      chk({alt, lc.code}, {1'h1, C_ALT});
   endtask : t_cfg
   task automatic print_verdict;
      $display("checks %0d failures %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (5000) @(posedge clock_i);
      fail_count++;
      print_verdict();
   end
   initial begin
      repeat (10) @(posedge clock_i);
      rst_b_i <= 1'h1;
      t_attr();
      t_bold();
      t_status();
      t_cfg();
      print_verdict();
   end
endmodule : tb
